// File: inc/fsp_pkg.sv
// Package: constants for the flash security and protection option block
`default_nettype none
package fsp_pkg;
  // Register byte offsets on the bus
  localparam logic [3:0] OFS_OPTION = 4'h0;
  localparam logic [3:0] OFS_CONFIG = 4'h4;
  localparam logic [3:0] OFS_PROTECT = 4'h8;
  localparam logic [3:0] OFS_KEY_LO = 4'hc;
  // Option register fields
  localparam int OPT_KEY_EN_BIT = 7;
  localparam int OPT_NORED_BIT = 6;
  localparam logic [7:0] OPT_READ_MASK = 8'hc3;
  localparam logic [1:0] SEC_UNSECURED = 2'h2;
  // Config register fields
  localparam int CFG_KEY_ACC_BIT = 5;
  localparam logic [7:0] CFG_WR_MASK = 8'he0;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // Protect register fields and option register reset value
  localparam int PROT_DIS_BIT = 0;
  localparam logic [7:0] PROT_RESET = 8'hff;
  localparam logic [7:0] OPT_RESET = 8'hff;
  // Flash address width and key address window
  localparam int ADDR_W = 16;
  localparam logic [15:0] KEY_BASE = 16'hffb0;
  localparam int KEY_BYTES = 8;
  // Loading state machine
  typedef enum logic [2:0]
  {
    ST_LOAD = 3'b001,
    ST_RUN = 3'b010,
    ST_IDLE = 3'b100
  } fsp_state_t;
endpackage : fsp_pkg
`default_nettype wire

// File: verilog/fsp_key_cmp.sv
// Backdoor key comparator: collects eight bytes by index, checks all at once on compare
`default_nettype none
module fsp_key_cmp
  import fsp_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic key_wr,
  input wire logic [2:0] key_idx,
  input wire logic [7:0] key_data,
  input wire logic [63:0] key_store,
  input wire logic compare,
  output logic match
);
  logic [7:0] got [KEY_BYTES];
  logic [KEY_BYTES-1:0] seen;
  logic [KEY_BYTES-1:0] ok;
  logic all_ok;

  // Per-byte comparison against the stored key
  genvar g;
  generate
    for (g = 0; g < KEY_BYTES; g = g + 1)
    begin : g_cmp
      assign ok[g] = seen[g] && (got[g] == key_store[63-8*g -: 8]);
    end
  endgenerate
  assign all_ok = &ok;

  // Capture key bytes; a compare consumes the set, so retries restart
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      seen <= '0;
      match <= 1'b0;
      for (int i = 0; i < KEY_BYTES; i++)
        got[i] <= 8'h00;
    end
    else
    begin
      match <= compare && all_ok;
      if (compare)
        seen <= '0;
      else if (key_wr)
      begin
        got[key_idx] <= key_data;
        seen[key_idx] <= 1'b1;
      end
    end
  end
endmodule : fsp_key_cmp
`default_nettype wire

// File: verilog/fsp_prot_chk.sv
// Protection check of a flash address against the protect register
`default_nettype none
module fsp_prot_chk
  import fsp_pkg::*;
(
  input wire logic [7:0] protect,
  input wire logic [ADDR_W-1:0] addr,
  output logic prot_hit
);
  logic [ADDR_W-1:0] last_free;

  // Select field forms top seven bits, rest all ones
  assign last_free = {protect[7:1], {(ADDR_W-7){1'b1}}};
  assign prot_hit = !protect[PROT_DIS_BIT] && (addr > last_free);
endmodule : fsp_prot_chk
`default_nettype wire

// File: verilog/fsp_top.sv
// Flash option, configuration and protection registers with security
//
// Chosen here: the register addresses and register access over Avalon-MM.
`default_nettype none
module fsp_top
  import fsp_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Access source qualifiers for the current bus access
  input wire logic src_debug,
  input wire logic src_secure,
  // Nonvolatile bytes and key store
  input wire logic [7:0] option_flash_byte,
  input wire logic [7:0] protect_flash_byte,
  input wire logic [63:0] backdoor_key_store,
  // CPU flash write, into the key address window or elsewhere
  input wire logic flash_wr,
  input wire logic [ADDR_W-1:0] flash_wr_addr,
  input wire logic [7:0] flash_wr_data,
  output logic cmd_start,
  // Command registration from the command engine
  input wire logic cmd_register,
  input wire logic cmd_is_modify,
  input wire logic [ADDR_W-1:0] cmd_addr,
  output logic cmd_accept,
  input wire logic blank_ok,
  input wire logic viol_clear,
  output logic protection_violation_flag,
  // Security outputs
  input wire logic mem_req_unsecured,
  output logic mem_block,
  output logic secured,
  output logic vector_redirect_disable
);
  fsp_state_t state;
  fsp_state_t next_state;
  logic [7:0] option_register;
  logic [7:0] flash_config_register;
  logic [7:0] protect_register;
  logic [1:0] security_code;
  logic key_write_access;
  logic backdoor_key_enable;
  logic key_match;
  logic prot_hit;
  logic key_wr;
  logic compare;
  logic wr_cfg;
  logic wr_prot;
  logic prot_wr_ok;
  logic rd_pend;
  logic [7:0] rd_byte;
  logic in_key_window;

  // Decode writes; ignored while reset bytes are still loading
  assign wr_cfg = avs_write && !avs_waitrequest && avs_byteenable[0]
                  && avs_address == OFS_CONFIG;
  assign wr_prot = avs_write && !avs_waitrequest && avs_byteenable[0]
                   && avs_address == OFS_PROTECT;
  assign key_write_access = flash_config_register[CFG_KEY_ACC_BIT];
  assign backdoor_key_enable = option_register[OPT_KEY_EN_BIT];
  assign vector_redirect_disable = option_register[OPT_NORED_BIT];
  assign in_key_window = flash_wr_addr[ADDR_W-1:3] == KEY_BASE[ADDR_W-1:3];

  // Key window writes with key access go to comparator only from a secure non-debug source and never start a command; other writes start a command
  assign key_wr = flash_wr && in_key_window && key_write_access
                  && src_secure && !src_debug;
  assign cmd_start = flash_wr && !(in_key_window && key_write_access);

  // Clearing key access triggers comparison
  assign compare = wr_cfg && key_write_access
                   && !avs_writedata[CFG_KEY_ACC_BIT];

  // Only pattern one-zero is unsecured
  assign secured = security_code != SEC_UNSECURED;
  assign mem_block = secured && mem_req_unsecured;

  // Debug writes anything; otherwise only lower select when enabled
  assign prot_wr_ok = src_debug
                      || (!protect_register[PROT_DIS_BIT]
                      && avs_writedata[7:1] < protect_register[7:1]);

  // Protected erase or program is discarded
  assign cmd_accept = cmd_register && !(cmd_is_modify && prot_hit);

  // Read mux; reserved bits of option read zero
  assign rd_byte = (avs_address == OFS_OPTION)
                   ? (option_register & OPT_READ_MASK)
                   : (avs_address == OFS_CONFIG) ? flash_config_register
                   : (avs_address == OFS_PROTECT) ? protect_register
                   : 8'h00;

  fsp_key_cmp u_key
  (
    .clk(clk),
    .rstn(rstn),
    .key_wr(key_wr),
    .key_idx(flash_wr_addr[2:0]),
    .key_data(flash_wr_data),
    .key_store(backdoor_key_store),
    .compare(compare),
    .match(key_match)
  );

  fsp_prot_chk u_prot
  (
    .protect(protect_register),
    .addr(cmd_addr),
    .prot_hit(prot_hit)
  );

  // Load state sequencing: one cycle of load after reset release
  always_comb
  begin
    case (state)
      ST_LOAD: next_state = ST_RUN;
      ST_RUN: next_state = ST_RUN;
      default: next_state = ST_LOAD;
    endcase
  end

  // Bus stalls while loading; reads take one wait cycle
  assign avs_waitrequest = (state != ST_RUN) || (avs_read && !rd_pend);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // Option image: loaded at reset, never written by software
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      option_register <= OPT_RESET;
    else if (state == ST_LOAD)
      option_register <= option_flash_byte;
  end

  // Security code follows option byte, then unlock events
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      security_code <= 2'h0;
    else if (state == ST_LOAD)
      security_code <= option_flash_byte[1:0];
    else if ((key_match && backdoor_key_enable) || blank_ok)
      security_code <= SEC_UNSECURED;
  end

  // Config: upper three bits writable, cleared at reset
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      flash_config_register <= CFG_RESET;
    else if (wr_cfg)
      flash_config_register <= avs_writedata[7:0] & CFG_WR_MASK;
  end

  // Protect image: loaded at reset, guarded writes
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      protect_register <= PROT_RESET;
    else if (state == ST_LOAD)
      protect_register <= protect_flash_byte;
    else if (wr_prot && prot_wr_ok)
      protect_register <= src_debug ? avs_writedata[7:0]
                          : {avs_writedata[7:1], 1'b0};
  end

  // Violation flag: set wins over clear
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      protection_violation_flag <= 1'b0;
    else if (cmd_register && cmd_is_modify && prot_hit)
      protection_violation_flag <= 1'b1;
    else if (viol_clear)
      protection_violation_flag <= 1'b0;
  end

  // Read data registered, answered on second cycle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_pend <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      rd_pend <= avs_read && !rd_pend && state == ST_RUN;
      if (avs_read && !rd_pend)
        avs_readdata <= {24'h00_0000, rd_byte};
    end
  end

  // Assertions
  a_opt_ro: assert property (@(posedge clk) disable iff (!rstn)
    state == ST_RUN && $past(state) == ST_RUN |-> $stable(option_register))
    else $error("option register changed after load");
  a_sec_decode: assert property (@(posedge clk) disable iff (!rstn)
    secured == (security_code != 2'h2))
    else $error("security decode wrong");
  a_key_gate: assert property (@(posedge clk) disable iff (!rstn)
    $past(state) == ST_RUN && !backdoor_key_enable && !$past(blank_ok)
    && $past(secured) |-> secured)
    else $error("unlocked with key disabled");
  a_cfg_low: assert property (@(posedge clk) disable iff (!rstn)
    flash_config_register[4:0] == 5'h00)
    else $error("config low bits nonzero");
  a_prot_lock: assert property (@(posedge clk) disable iff (!rstn)
    $past(state) == ST_RUN && $past(protect_register[0]) && !$past(src_debug)
    |-> protect_register == $past(protect_register))
    else $error("protect changed while disabled");
  a_prot_inc: assert property (@(posedge clk) disable iff (!rstn)
    $past(state) == ST_RUN && !$past(src_debug)
    |-> protect_register[7:1] <= $past(protect_register[7:1]))
    else $error("protection decreased");
  a_viol_set: assert property (@(posedge clk) disable iff (!rstn)
    cmd_register && cmd_is_modify && prot_hit
    |-> !cmd_accept ##1 protection_violation_flag)
    else $error("violation not flagged");
  a_mem_block: assert property (@(posedge clk) disable iff (!rstn)
    mem_req_unsecured && secured |-> mem_block)
    else $error("unsecured access not blocked");
  a_key_src: assert property (@(posedge clk) disable iff (!rstn)
    src_debug |-> !key_wr)
    else $error("debug wrote key");
  c_unlock: cover property (@(posedge clk) disable iff (!rstn)
    $fell(secured));
  c_viol: cover property (@(posedge clk) disable iff (!rstn)
    $rose(protection_violation_flag));
  c_prot_wr: cover property (@(posedge clk) disable iff (!rstn)
    wr_prot && prot_wr_ok);
endmodule : fsp_top
`default_nettype wire

// File: tb/fsp_tb.sv
// Self-checking bench for the flash option and protection block
`default_nettype none
`define CHK(a, e) \
  begin \
    tests_run++; \
    if ((a) !== (e)) \
    begin \
      fails++; \
      $display("[ERR] %0t got %h want %h", $time, (a), (e)); \
    end \
  end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import fsp_pkg::*;
  typedef struct packed
  {
    logic wr;
    logic [3:0] a;
    logic [7:0] d;
    logic dbg;
    logic [7:0] exp;
  } fsp_row_t;
  logic clk, rstn, avs_read, avs_write, avs_waitrequest, src_debug;
  logic src_secure, flash_wr, cmd_start, cmd_register, cmd_is_modify;
  logic cmd_accept, blank_ok, viol_clear, protection_violation_flag;
  logic mem_req_unsecured, mem_block, secured, vector_redirect_disable;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [7:0] option_flash_byte, protect_flash_byte, flash_wr_data;
  logic [63:0] backdoor_key_store;
  logic [15:0] flash_wr_addr, cmd_addr;
  int fails = 0;
  int tests_run = 0;
  // Register cases: writes first, then the read-back expectation
  fsp_row_t rows [11] = '{
    '{1'b0, 4'h0, 8'h00, 1'b0, 8'h83},
    '{1'b1, 4'h0, 8'h00, 1'b0, 8'h83},
    '{1'b1, 4'h4, 8'hff, 1'b0, 8'he0},
    '{1'b1, 4'h4, 8'h00, 1'b0, 8'h00},
    '{1'b0, 4'h8, 8'h00, 1'b0, 8'hf0},
    '{1'b1, 4'h8, 8'hf8, 1'b0, 8'hf0},
    '{1'b1, 4'h8, 8'he0, 1'b0, 8'he0},
    '{1'b1, 4'h8, 8'hff, 1'b1, 8'hff},
    '{1'b1, 4'h8, 8'h10, 1'b0, 8'hff},
    '{1'b1, 4'h8, 8'he0, 1'b1, 8'he0},
    '{1'b0, 4'hc, 8'h00, 1'b0, 8'h00}};
  fsp_top fsp_top_i (.clk, .rstn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .src_debug, .src_secure, .option_flash_byte, .protect_flash_byte,
    .backdoor_key_store, .flash_wr, .flash_wr_addr, .flash_wr_data,
    .cmd_start, .cmd_register, .cmd_is_modify, .cmd_addr, .cmd_accept,
    .blank_ok, .viol_clear, .protection_violation_flag, .mem_req_unsecured,
    .mem_block, .secured, .vector_redirect_disable);
  // 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Verdict in one place
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done
  // Reset with a chosen option byte; held 16 cycles
  task automatic rst(input logic [7:0] opt);
    rstn <= 1'b0;
    option_flash_byte <= opt;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : rst
  // One Avalon transfer; request held until waitrequest seen low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [7:0] d, input logic dbg);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'h0, d};
    src_debug <= dbg;
    @(negedge clk);
    while (avs_waitrequest !== 1'b0 && n < 50)
    begin
      n++;
      @(negedge clk);
    end
    if (n == 50)
    begin
      fails++;
      test_done();
    end
    q = avs_readdata;
    @(posedge clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    src_debug <= 1'b0;
    @(posedge clk);
  endtask : bus
  // Eight key-window writes back to back, byte 0 first
  task automatic keys(input logic dbg, input logic cs);
    for (int i = 0; i < KEY_BYTES; i++)
    begin
      flash_wr <= 1'b1;
      flash_wr_addr <= KEY_BASE + 16'(i);
      flash_wr_data <= backdoor_key_store[63 - 8 * i -: 8];
      src_debug <= dbg;
      src_secure <= ~dbg;
      @(negedge clk);
      if (!dbg)
        `CHK(cmd_start, cs)
      @(posedge clk);
    end
    flash_wr <= 1'b0;
    src_debug <= 1'b0;
    @(posedge clk);
  endtask : keys
  // Unlock attempt: open key access, send key, close access
  task automatic unlock(input logic dbg);
    bus(1'b1, OFS_CONFIG, 8'h20, 1'b0);
    keys(dbg, 1'b0);
    bus(1'b1, OFS_CONFIG, 8'h00, 1'b0);
    repeat (3) @(posedge clk);
  endtask : unlock
  // Register a modify command and check acceptance and flag
  task automatic cmd(input logic [15:0] a, input logic e);
    cmd_register <= 1'b1;
    cmd_is_modify <= 1'b1;
    cmd_addr <= a;
    @(negedge clk);
    `CHK(cmd_accept, e)
    @(posedge clk);
    cmd_register <= 1'b0;
    @(negedge clk);
    `CHK(protection_violation_flag, ~e)
    @(posedge clk);
  endtask : cmd
  initial
  begin
    {rstn, avs_read, avs_write, src_debug, src_secure, flash_wr} = '0;
    {cmd_register, cmd_is_modify, blank_ok, viol_clear} = '0;
    avs_address = '0;
    avs_writedata = '0;
    avs_byteenable = 4'h1;
    option_flash_byte = 8'hbf;
    protect_flash_byte = 8'hf0;
    backdoor_key_store = 64'h0123456789abcdef;
    flash_wr_addr = '0;
    flash_wr_data = '0;
    cmd_addr = '0;
    mem_req_unsecured = 1'b1;
    // Every security code pattern, one reset each
    for (int i = 0; i < 4; i++)
    begin
      rst({6'h2f, 2'(i)});
      @(negedge clk);
      `CHK(secured, 1'(i != 2))
    end
    rst(8'hbf);
    @(negedge clk);
    `CHK(vector_redirect_disable, 1'b0)
    `CHK(mem_block, 1'b1)
    @(posedge clk);
    foreach (rows[i])
    begin
      if (rows[i].wr)
        bus(1'b1, rows[i].a, rows[i].d, rows[i].dbg);
      bus(1'b0, rows[i].a, 8'h00, 1'b0);
      `CHK(q, {24'h0, rows[i].exp})
    end
    keys(1'b0, 1'b1);
    unlock(1'b1);
    `CHK(secured, 1'b1)
    unlock(1'b0);
    @(negedge clk);
    `CHK(secured, 1'b0)
    `CHK(mem_block, 1'b0)
    @(posedge clk);
    // Protect is e0 here: last unprotected address e1ff
    cmd(16'he1ff, 1'b1);
    cmd(16'he200, 1'b0);
    viol_clear <= 1'b1;
    @(posedge clk);
    viol_clear <= 1'b0;
    @(negedge clk);
    `CHK(protection_violation_flag, 1'b0)
    @(posedge clk);
    bus(1'b1, OFS_PROTECT, 8'he1, 1'b1);
    cmd(16'hffff, 1'b1);
    // Key mechanism disabled by the option byte
    rst(8'h7f);
    @(negedge clk);
    `CHK(vector_redirect_disable, 1'b1)
    @(posedge clk);
    unlock(1'b0);
    `CHK(secured, 1'b1)
    blank_ok <= 1'b1;
    @(posedge clk);
    blank_ok <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK(secured, 1'b0)
    test_done();
  end
endmodule : tb
`default_nettype wire
